// *** rtl/ebtt_timer.sv ***
// eight-bit trigger timer with apb registers and waveform output
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/100ps
module ebtt_timer
    import ebtt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_count_clock_in,
    input  wire logic        counter_reset_in,
    input  wire logic        trigger_in,
    output logic             waveform_out,
    output logic             match_irq,
    output logic             wrap_irq
);
    ebtt_state_t st;
    ebtt_state_t next_st;
    logic        rst_int_n;
    logic [1:0]  rst_q;

    // first flop of each synchroniser only feeds the next stage
    function automatic ebtt_sync_t sync_step(input ebtt_sync_t s, input logic pin);
        sync_step = '{meta: {s.meta[0], pin}, s2: s.meta[1], s3: s.s2};
    endfunction

    function automatic logic [7:0] addr_word(input logic [7:0] a);
        addr_word = {a[7:2], 2'b00};
    endfunction

    // stable agreed level and edges on the filtered pin
    function automatic logic rose(input ebtt_sync_t s);
        rose = s.meta[1] & s.s2 & ~s.s3;
    endfunction
    function automatic logic fell(input ebtt_sync_t s);
        fell = ~s.meta[1] & ~s.s2 & s.s3;
    endfunction

    // apply one match action to a level
    function automatic logic act(input logic [1:0] a, input logic lvl);
        unique case (a)
            EBTT_ACT_KEEP: act = lvl;
            EBTT_ACT_LOW:  act = 1'b0;
            EBTT_ACT_HIGH: act = 1'b1;
            EBTT_ACT_TOG:  act = ~lvl;
        endcase
    endfunction

    assign rst_int_n = rst_q[1];

    logic       wr_en;
    logic       rd_en;
    logic [7:0] wa;
    logic [7:0] rd_val;
    logic       tick;
    logic       match_a;
    logic       match_b;
    logic       clr;
    logic       trig_edge;
    logic       incr;
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [1:0] act_win;
    logic [2:0] cks;
    logic       icks;
    logic [EBTT_PRE_W-1:0] pre_old;
    logic       div_fall;

    always_comb begin
        next_st  = st;
        wa       = addr_word(paddr);
        wr_en    = psel & penable & pwrite & ~st.pready;
        rd_en    = psel & penable & ~pwrite & ~st.pready;
        cks      = st.cci[2:0];
        icks     = st.trig_cfg[0];
        act_a    = st.out_sel[1:0];
        act_b    = st.out_sel[3:2];
        // pin inputs through four flops
        next_st.s_clk = sync_step(st.s_clk, external_count_clock_in);
        next_st.s_rst = sync_step(st.s_rst, counter_reset_in);
        next_st.s_trg = sync_step(st.s_trg, trigger_in);
        // prescaler free-runs; a falling tap is the internal count edge
        next_st.pre = st.pre + 1'b1;
        pre_old     = st.pre;
        div_fall    = 1'b0;
        // count clock choice, prohibited codes give no tick
        unique case (cks)
            3'h1: div_fall = icks ? (pre_old[2:0] == 3'h7) : (pre_old[1:0] == 2'h3);          // R19
            3'h2: div_fall = icks ? (pre_old[4:0] == 5'h1f) : (pre_old[3:0] == 4'hf);
            3'h3: div_fall = icks ? (pre_old == 7'h7f) : (pre_old[5:0] == 6'h3f);
            default: div_fall = 1'b0;
        endcase
        unique case (cks)
            3'h5: tick = rose(st.s_clk);                                                  // R19
            3'h6: tick = fell(st.s_clk);
            3'h7: tick = rose(st.s_clk) | fell(st.s_clk);
            default: tick = div_fall;                                                     // R12
        endcase
        // matches pulse on a count tick while the values are equal; writes to a constant mask it
        match_a = (st.counter == st.const_a) && tick
                  && !(wr_en && wa == EBTT_OFF_CONST_A);                                  // R14
        match_b = (st.counter == st.const_b) && tick
                  && !(wr_en && wa == EBTT_OFF_CONST_B);                                  // R14
        unique case (st.cci[4:3])
            EBTT_CLR_A:   clr = match_a;                                                  // R16
            EBTT_CLR_B:   clr = match_b;                                                  // R16
            EBTT_CLR_PIN: clr = rose(st.s_rst);                                           // R17
            default:      clr = 1'b0;
        endcase
        unique case (st.trig_cfg[4:3])
            EBTT_EDGE_RISE: trig_edge = rose(st.s_trg);                                   // R9
            EBTT_EDGE_FALL: trig_edge = fell(st.s_trg);                                   // R9
            EBTT_ACT_TOG:   trig_edge = rose(st.s_trg) | fell(st.s_trg);                  // R9
            default:        trig_edge = 1'b0;
        endcase
        // halt and restart only when trigger mode is on
        if (!st.trig_cfg[2]) begin
            next_st.run = EBTT_RUN;                                                       // R10
        end else if (clr) begin
            next_st.run = EBTT_HALT;                                                      // R11
        end else if (trig_edge) begin
            next_st.run = EBTT_RUN;                                                       // R11
        end
        incr = tick && (st.run == EBTT_RUN);
        // clear beats cpu write, cpu write beats increment
        if (clr) begin
            next_st.counter = EBTT_ZERO8;
        end else if (wr_en && wa == EBTT_OFF_COUNTER) begin
            next_st.counter = pwdata[7:0];
        end else if (incr) begin
            next_st.counter = st.counter + 1'b1;
        end
        // combined action when both match
        if (match_a && match_b) begin
            if (act_a == EBTT_ACT_TOG || act_b == EBTT_ACT_TOG) begin
                act_win = EBTT_ACT_TOG;                                                   // R21
            end else if (act_a == EBTT_ACT_HIGH || act_b == EBTT_ACT_HIGH) begin
                act_win = EBTT_ACT_HIGH;                                                  // R21
            end else if (act_a == EBTT_ACT_LOW || act_b == EBTT_ACT_LOW) begin
                act_win = EBTT_ACT_LOW;
            end else begin
                act_win = EBTT_ACT_KEEP;
            end
        end else if (match_a) begin
            act_win = act_a;                                                              // R7
        end else if (match_b) begin
            act_win = act_b;                                                              // R6
        end else begin
            act_win = EBTT_ACT_KEEP;                                                      // R8
        end
        next_st.wave = act(act_win, st.wave);
        // register writes; flags clear only after a one was read
        if (wr_en) begin
            unique case (wa)
                EBTT_OFF_CONST_A: next_st.const_a = pwdata[7:0];
                EBTT_OFF_CONST_B: next_st.const_b = pwdata[7:0];
                EBTT_OFF_CCI:     next_st.cci     = pwdata[7:0];
                EBTT_OFF_TRIG:    next_st.trig_cfg = pwdata[4:0] & EBTT_TRIG_WMASK[4:0];
                EBTT_OFF_STATUS: begin
                    next_st.out_sel = pwdata[3:0];
                    if (!pwdata[EBTT_B_FLAG_B] && st.read_one[2]) next_st.flag_b = 1'b0;   // R3
                    if (!pwdata[EBTT_B_FLAG_A] && st.read_one[1]) next_st.flag_a = 1'b0;   // R3
                    if (!pwdata[EBTT_B_WRAP] && st.read_one[0]) next_st.wrap = 1'b0;       // R3 R22
                    next_st.read_one = 3'h0;
                end
                default: ;
            endcase
        end
        // set wins over a clear in the same cycle
        if (match_b) next_st.flag_b = 1'b1;                                               // R1
        if (match_a) next_st.flag_a = 1'b1;                                               // R2
        if (incr && !clr && !(wr_en && wa == EBTT_OFF_COUNTER) && st.counter == EBTT_CNT_MAX) begin
            next_st.wrap = 1'b1;                                                          // R4
        end
        // read mux, reserved bits read one
        unique case (wa)
            EBTT_OFF_COUNTER: rd_val = st.counter;
            EBTT_OFF_CONST_A: rd_val = st.const_a;
            EBTT_OFF_CONST_B: rd_val = st.const_b;
            EBTT_OFF_CCI:     rd_val = st.cci;
            EBTT_OFF_STATUS:  rd_val = {st.flag_b, st.flag_a, st.wrap, 1'b0, st.out_sel} | EBTT_STAT_ONES; // R5
            EBTT_OFF_TRIG:    rd_val = {3'h0, st.trig_cfg} | EBTT_TRIG_ONES;              // R5
            default:          rd_val = EBTT_ZERO8;
        endcase
        if (rd_en && wa == EBTT_OFF_STATUS) begin
            next_st.read_one = st.read_one | {st.flag_b, st.flag_a, st.wrap};             // R3
        end
        next_st.pready = psel & penable & ~st.pready;
        if (rd_en) begin
            next_st.prdata = {24'h000000, rd_val};
        end
        next_st.irq_wrap  = next_st.wrap & st.cci[5];                                     // R13
        next_st.irq_match = (next_st.flag_a & st.cci[6]) | (next_st.flag_b & st.cci[7]);  // R15
        next_st.rst_sync  = rst_q;
    end

    // reset release through two flops of its own, so the state struct has one driver
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end

    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            st.rst_sync  <= 2'h0;
            st.counter   <= EBTT_ZERO8;
            st.const_a   <= EBTT_CONST_RST;                                               // R20
            st.const_b   <= EBTT_CONST_RST;                                               // R20
            st.cci       <= EBTT_ZERO8;
            st.flag_b    <= 1'b0;
            st.flag_a    <= 1'b0;
            st.wrap      <= 1'b0;
            st.out_sel   <= 4'h0;
            st.trig_cfg  <= 5'h00;
            st.read_one  <= 3'h0;
            st.wave      <= 1'b0;                                                         // R8
            st.run       <= EBTT_RUN;
            st.pre       <= '0;
            st.s_clk     <= '0;
            st.s_rst     <= '0;
            st.s_trg     <= '0;
            st.prdata    <= 32'h00000000;
            st.pready    <= 1'b0;
            st.irq_match <= 1'b0;
            st.irq_wrap  <= 1'b0;
        end else if (clk_en) begin
            st.rst_sync  <= next_st.rst_sync;
            st.counter   <= next_st.counter;
            st.const_a   <= next_st.const_a;
            st.const_b   <= next_st.const_b;
            st.cci       <= next_st.cci;
            st.flag_b    <= next_st.flag_b;
            st.flag_a    <= next_st.flag_a;
            st.wrap      <= next_st.wrap;
            st.out_sel   <= next_st.out_sel;
            st.trig_cfg  <= next_st.trig_cfg;
            st.read_one  <= next_st.read_one;
            st.wave      <= next_st.wave;
            st.run       <= next_st.run;
            st.pre       <= next_st.pre;
            st.s_clk     <= next_st.s_clk;
            st.s_rst     <= next_st.s_rst;
            st.s_trg     <= next_st.s_trg;
            st.prdata    <= next_st.prdata;
            st.pready    <= next_st.pready;
            st.irq_match <= next_st.irq_match;
            st.irq_wrap  <= next_st.irq_wrap;
        end
    end

    assign prdata       = st.prdata;
    assign pready       = st.pready;
    assign pslverr      = 1'b0;
    assign waveform_out = st.wave;
    assign match_irq    = st.irq_match;
    assign wrap_irq     = st.irq_wrap;
endmodule

// *** rtl/ebtt_pkg.sv ***
// constants, register map and carrier types of the eight-bit trigger timer
// How it works
// R1: counter equals second constant sets second flag
// R2: counter equals first constant sets first flag
// R3: flags clear by zero write after one-read
// R4: wrap from ff to 00 sets wrap flag
// R5: unused status and trigger bits read one
// R6: second match action: keep, low, high, toggle
// R7: first match action: keep, low, high, toggle
// R8: waveform output zero until first match
// R9: trigger edge: off, rising, falling, both
// R10: trigger disabled: no start, no halt
// R11: trigger enabled: halt on clear, resume edge
// R12: count clock from select bits, then count
// R13: wrap interrupt when flag and enable set
// R14: compare continuously, match at last equal state
// R15: match interrupt when flag and enable set
// R16: clear source 01/10 clears on match
// R17: clear source 11 clears on reset-pin rise
// R18: outside holds reset pulse 1.5 clocks
// R19: prescaler 4..128 or external edge choices
// R20: both constants reset to all ones
// R21: simultaneous matches: toggle, high, low priority
// R22: writing one to a flag changes nothing
package ebtt_pkg;
    localparam logic [7:0] EBTT_OFF_COUNTER = 8'h00;
    localparam logic [7:0] EBTT_OFF_CONST_A = 8'h04;
    localparam logic [7:0] EBTT_OFF_CONST_B = 8'h08;
    localparam logic [7:0] EBTT_OFF_CCI     = 8'h0c;
    localparam logic [7:0] EBTT_OFF_STATUS  = 8'h10;
    localparam logic [7:0] EBTT_OFF_TRIG    = 8'h14;

    localparam logic [7:0] EBTT_CONST_RST   = 8'hff;
    localparam logic [7:0] EBTT_CNT_MAX     = 8'hff;
    localparam logic [7:0] EBTT_ZERO8       = 8'h00;
    localparam logic [7:0] EBTT_STAT_ONES   = 8'h10;
    localparam logic [7:0] EBTT_TRIG_ONES   = 8'he2;
    localparam logic [7:0] EBTT_TRIG_WMASK  = 8'h1d;

    // status bit positions
    localparam int EBTT_B_FLAG_B = 7;
    localparam int EBTT_B_FLAG_A = 6;
    localparam int EBTT_B_WRAP   = 5;

    // clear source encodings
    localparam logic [1:0] EBTT_CLR_NONE = 2'h0;
    localparam logic [1:0] EBTT_CLR_A    = 2'h1;
    localparam logic [1:0] EBTT_CLR_B    = 2'h2;
    localparam logic [1:0] EBTT_CLR_PIN  = 2'h3;

    // output action and trigger edge encodings
    localparam logic [1:0] EBTT_ACT_KEEP = 2'h0;
    localparam logic [1:0] EBTT_ACT_LOW  = 2'h1;
    localparam logic [1:0] EBTT_ACT_HIGH = 2'h2;
    localparam logic [1:0] EBTT_ACT_TOG  = 2'h3;

    localparam logic [1:0] EBTT_EDGE_RISE = 2'h1;
    localparam logic [1:0] EBTT_EDGE_FALL = 2'h2;

    localparam int EBTT_PRE_W = 7;

    typedef enum logic [0:0] {
        EBTT_RUN  = 1'b0,
        EBTT_HALT = 1'b1
    } ebtt_run_t;

    typedef struct packed {
        logic [1:0] meta;
        logic       s2;
        logic       s3;
    } ebtt_sync_t;

    typedef struct packed {
        logic [1:0]            rst_sync;
        logic [7:0]            counter;
        logic [7:0]            const_a;
        logic [7:0]            const_b;
        logic [7:0]            cci;
        logic                  flag_b;
        logic                  flag_a;
        logic                  wrap;
        logic [3:0]            out_sel;
        logic [4:0]            trig_cfg;
        logic [2:0]            read_one;
        logic                  wave;
        ebtt_run_t             run;
        logic [EBTT_PRE_W-1:0] pre;
        ebtt_sync_t            s_clk;
        ebtt_sync_t            s_rst;
        ebtt_sync_t            s_trg;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  irq_match;
        logic                  irq_wrap;
    } ebtt_state_t;
endpackage

// *** test/ebtt_timer_sva.sv ***
// port-level assertion checker for the eight-bit trigger timer
`timescale 1ns/100ps
module ebtt_timer_sva
    import ebtt_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        waveform_out,
    input wire logic        match_irq,
    input wire logic        wrap_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [2:0] wr_hist;
    logic       rd_st;
    logic       rd_tr;
    // reads of the two registers with read-one bits
    assign rd_st = psel & penable & pready & !pwrite & (paddr == EBTT_OFF_STATUS);
    assign rd_tr = psel & penable & pready & !pwrite & (paddr == EBTT_OFF_TRIG);
    // recent status or control writes: the only way a request may drop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_hist <= 3'h0;
        end else begin
            wr_hist <= {wr_hist[1:0], psel & penable & pwrite & (paddr == EBTT_OFF_STATUS | paddr == EBTT_OFF_CCI)};
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        penable && !pready ##1 pready ##1 !pready;
    endsequence
    AST_APB_ANSWER: assert property (s_setup |=> s_answer) else $error("apb answer out of step");
    AST_STATUS_ONES: assert property (rd_st |-> prdata[4]) else $error("status spare bit not one");
    AST_TRIG_ONES: assert property (rd_tr |-> prdata[7:5] == 3'h7 && prdata[1]) else $error("trig spare bits");
    AST_WAVE_RESET: assert property ($rose(rst_n) |-> !waveform_out [*3]) else $error("wave high after reset");
    AST_WRAP_HOLD: assert property ($fell(wrap_irq) |-> |wr_hist) else $error("wrap request dropped");
    AST_MATCH_HOLD: assert property ($fell(match_irq) |-> |wr_hist) else $error("match request dropped");
    AST_WRAP_READ: assert property (rd_st && $past(wrap_irq, 2) |-> prdata[5]) else $error("wrap flag low");
    AST_MATCH_READ: assert property (rd_st && $past(match_irq, 2) |-> |prdata[7:6]) else $error("match flags low");
endmodule
bind ebtt_timer ebtt_timer_sva chk_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .waveform_out(waveform_out), .match_irq(match_irq),
    .wrap_irq(wrap_irq));

// *** test/ebtt_pins.sv ***
// pin-side model: external count clock, counter reset pulse and trigger
`timescale 1ns/100ps
module ebtt_pins (
    input wire logic clk,
    output logic     ext_clk,
    output logic     rst_pin,
    output logic     trg
);
    // levels start low; each level lasts past the input synchronisers
    initial begin
        ext_clk = 1'b0;
        rst_pin = 1'b0;
        trg     = 1'b0;
    end
    task automatic hold_lvl(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic ext_pulse();
        @(posedge clk) ext_clk <= 1'b1;
        hold_lvl(5);
        ext_clk <= 1'b0;
        hold_lvl(5);
    endtask
    // six clocks high, well over the minimum width
    task automatic rst_pulse();
        @(posedge clk) rst_pin <= 1'b1;
        hold_lvl(6);
        rst_pin <= 1'b0;
        hold_lvl(6);
    endtask
    task automatic set_trg(input logic v);
        @(posedge clk) trg <= v;
        hold_lvl(6);
    endtask
endmodule

// *** test/testbench.sv ***
// self-checking bench: apb master, pin model and reference timer model
`timescale 1ns/100ps
module testbench;
    import ebtt_pkg::*;
    logic        clk, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
    logic        pready, pslverr, wave_o, mirq, wirq, ext_clk, rst_pin, trg, halted = 1'b0, wave = 1'b0;
    logic [7:0]  paddr = 8'h00, cci = 8'h00, trc = 8'h00, rv;
    logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h3a43;
    logic [3:0]  acts = 4'h0;
    logic [2:0]  fl = 3'h0, seen = 3'h0;
    int          cnt = 0, ca = 255, cb = 255, n_fail = 0, cmp_count = 0, cycles = 0;
    ebtt_timer dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_clock_in(ext_clk), .counter_reset_in(rst_pin), .trigger_in(trg),
        .waveform_out(wave_o), .match_irq(mirq), .wrap_irq(wirq));
    ebtt_pins pins_u (.clk(clk), .ext_clk(ext_clk), .rst_pin(rst_pin), .trg(trg));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard, far above the few thousand cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_fail++;
            complete_run();
        end
    end
    function automatic logic [7:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(a, 1'b1, d);
        case (a)
            EBTT_OFF_COUNTER: cnt = d;
            EBTT_OFF_CONST_A: ca = d;
            EBTT_OFF_CONST_B: cb = d;
            EBTT_OFF_CCI: cci = d;
            EBTT_OFF_TRIG: trc = d & EBTT_TRIG_WMASK;
            EBTT_OFF_STATUS: begin
                fl = fl & (d[7:5] | ~seen);
                seen = 3'h0;
                acts = d[3:0];
            end
            default: ;
        endcase
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        apb(a, 1'b0, 8'h00);
        check(rd, {24'h0, e});
        if (a == EBTT_OFF_STATUS) seen = fl;
    endtask
    task automatic verify();
        rdchk(EBTT_OFF_COUNTER, cnt[7:0]);
        rdchk(EBTT_OFF_STATUS, {fl, 1'b1, acts});
        check({29'h0, wave_o, mirq, wirq}, {29'h0, wave, (fl[1] & cci[6]) | (fl[2] & cci[7]), fl[0] & cci[5]});
    endtask
    // n external count edges; clear replaces the increment
    task automatic tick(input int n);
        logic       ma, mb;
        logic [1:0] ta, tb;
        repeat (n) begin
            pins_u.ext_pulse();
            if (!halted) begin
                ma = (cnt == ca);
                mb = (cnt == cb);
                fl = fl | {mb, ma, 1'b0};
                ta = ma ? acts[1:0] : 2'h0;
                tb = mb ? acts[3:2] : 2'h0;
                if (ta == EBTT_ACT_TOG || tb == EBTT_ACT_TOG) wave = !wave;
                else if (ta == EBTT_ACT_HIGH || tb == EBTT_ACT_HIGH) wave = 1'b1;
                else if (ta == EBTT_ACT_LOW || tb == EBTT_ACT_LOW) wave = 1'b0;
                if ((cci[4:3] == EBTT_CLR_A && ma) || (cci[4:3] == EBTT_CLR_B && mb)) begin
                    cnt = 0;
                    halted = trc[2];
                end else begin
                    fl[0] = fl[0] | (cnt == 255);
                    cnt = (cnt + 1) % 256;
                end
            end
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk(EBTT_OFF_CONST_A, EBTT_CONST_RST);
        rdchk(EBTT_OFF_CONST_B, EBTT_CONST_RST);
        rdchk(8'h18, 8'h00);
        verify();
        // random control traffic with counting stopped
        repeat (4) begin
            rv = next_rand();
            wr(EBTT_OFF_TRIG, rv);
            rdchk(EBTT_OFF_TRIG, trc | EBTT_TRIG_ONES);
            rv = next_rand();
            wr(EBTT_OFF_CCI, rv & 8'hf8);
            rdchk(EBTT_OFF_CCI, cci);
        end
        // internal dividers: about eight counts each; a source switch may add one
        for (int k = 0; k < 6; k++) begin
            wr(EBTT_OFF_CCI, 8'h00);
            wr(EBTT_OFF_TRIG, {7'h0, k[0]});
            wr(EBTT_OFF_COUNTER, 8'h00);
            wr(EBTT_OFF_CCI, {5'h0, 3'(k / 2 + 1)});
            repeat ((4 << k) * 8) @(posedge clk);
            apb(EBTT_OFF_COUNTER, 1'b0, 8'h00);
            check({31'h0, rd[7:0] >= 8'd7 && rd[7:0] <= 8'd10}, 32'h1);
        end
        // match actions, clear sources and coinciding matches; stop the divider first
        wr(EBTT_OFF_CCI, 8'h00);
        wr(EBTT_OFF_TRIG, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rv = next_rand();
            wr(EBTT_OFF_COUNTER, 8'h00);
            wr(EBTT_OFF_CONST_A, {6'h0, rv[1:0]} + 8'h1);
            wr(EBTT_OFF_CONST_B, i[0] ? ca[7:0] : {6'h0, rv[3:2]} + 8'h2);
            wr(EBTT_OFF_CCI, {rv[7:5], i[1], !i[1], 3'h5});
            wr(EBTT_OFF_STATUS, {4'h0, i[1:0], i[2:1]});
            tick(rv[4] ? 3 : 7);
            verify();
        end
        wr(EBTT_OFF_STATUS, {4'hf, acts});
        wr(EBTT_OFF_STATUS, {4'h0, acts});
        verify();
        wr(EBTT_OFF_STATUS, {4'h0, acts});
        verify();
        // wrap from the top value with its request enabled
        wr(EBTT_OFF_CCI, 8'h25);
        wr(EBTT_OFF_COUNTER, 8'hfd);
        tick(4);
        verify();
        wr(EBTT_OFF_STATUS, {4'h0, acts});
        verify();
        // clear from the reset pin
        wr(EBTT_OFF_CCI, 8'h1d);
        pins_u.rst_pulse();
        cnt = 0;
        verify();
        // halt on clear, then each trigger edge choice; rising, falling and both restart, off leaves it halted
        for (int e = 0; e < 4; e++) begin
            wr(EBTT_OFF_COUNTER, 8'h00);
            wr(EBTT_OFF_CCI, 8'h0d);
            wr(EBTT_OFF_TRIG, {3'h0, e[1:0], 3'h4});
            tick(ca + 3);
            pins_u.set_trg(1'b1);
            halted = halted && !e[0];
            tick(2);
            pins_u.set_trg(1'b0);
            halted = halted && !e[1];
            tick(2);
            verify();
        end
        complete_run();
    end
endmodule
